// ===== inc/ocw_pkg.sv
// Constants, offsets and types of the overclock frequency and watchdog control block.
// Assumes a 100 MHz mclk and an 8-bit register port with a 4-bit address.
package ocw_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int WD_SHORT_SCALE_MS = 250;
  localparam int WD_LONG_SCALE_MS = 3000;
  localparam int WD_TICK_CYCLES = WD_SHORT_SCALE_MS * CYC_PER_MS;
  localparam int WD_LONG_UNITS = WD_LONG_SCALE_MS / WD_SHORT_SCALE_MS;
  localparam int RST_PULSE_MS = 20;
  localparam int RST_PULSE_CYCLES = RST_PULSE_MS * CYC_PER_MS;
  // ==========================================================
  // Widths
  localparam int N_W = 9;
  localparam int M_W = 7;
  localparam int IDX_W = 4;
  localparam int STRAP_W = 5;
  localparam int WD_TIMER_W = 3;
  localparam int WD_UNITS_W = 7;
  // ==========================================================
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SWIDX = 4'h1;
  localparam logic [3:0] REG_CPU_N_LO = 4'h2;
  localparam logic [3:0] REG_CPU_NM = 4'h3;
  localparam logic [3:0] REG_PCIE_N_LO = 4'h4;
  localparam logic [3:0] REG_HIGH_BITS = 4'h5;
  localparam logic [3:0] REG_REC_N_LO = 4'h6;
  localparam logic [3:0] REG_WDOG = 4'h7;
  localparam logic [3:0] REG_AUTOREC = 4'h8;
  localparam logic [3:0] REG_DYN1_LO = 4'h9;
  localparam logic [3:0] REG_DYN2_LO = 4'hA;
  localparam logic [3:0] REG_DYN3_LO = 4'hB;
  localparam logic [3:0] REG_DYN_HI = 4'hC;
  localparam logic [3:0] REG_STATUS = 4'hD;
  // ==========================================================
  // Field positions
  localparam int CTRL_CPU_PROG = 0;
  localparam int CTRL_PCIE_PROG = 1;
  localparam int CTRL_DYN_EN = 2;
  localparam int CTRL_OVERRIDE = 3;
  localparam int CTRL_SMOOTH_MAN = 4;
  localparam int CTRL_SMOOTH_PCIE = 5;
  localparam int HB_PCIE_N8 = 0;
  localparam int HB_REC_N8 = 1;
  localparam int WD_ENABLE = 0;
  localparam int WD_ALARM = 1;
  localparam int WD_SCALE = 2;
  localparam int WD_TIMER_LSB = 3;
  localparam int WD_RST_ONLY = 6;
  localparam int WD_REC_FROM_N = 7;
  // ==========================================================
  // Reset values
  localparam logic WD_SCALE_RST = 1'b1;
  localparam logic AUTOREC_RST = 1'b1;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    OCW_FUNC_LINK = 2'b00,
    OCW_FUNC_DOT = 2'b01,
    OCW_FUNC_SATA = 2'b10
  } ocw_func_e;
  typedef enum logic [1:0] {
    OCW_SRC_STRAP = 2'b00,
    OCW_SRC_SWIDX = 2'b01,
    OCW_SRC_PROG = 2'b10
  } ocw_src_e;
  typedef enum logic [1:0] {
    OCW_WD_IDLE = 2'b00,
    OCW_WD_COUNT = 2'b01,
    OCW_WD_PULSE = 2'b10,
    OCW_WD_HOLD = 2'b11
  } ocw_wd_state_e;
endpackage

// ===== inc/ocw_wdog_if.sv
// Watchdog carrier between control, timer and tick prescaler.
// Assumes all three parties run on mclk.
`timescale 1ns/1ps
interface ocw_wdog_if;
  logic tick;
  logic tick_clr;
  logic enable;
  logic restart;
  logic [ocw_pkg::WD_UNITS_W-1:0] load_units;
  logic timeout;
  logic pulse_active;
  modport ctrl (output enable, output restart, output load_units,
    input timeout, input pulse_active);
  modport timer (input tick, output tick_clr, input enable, input restart,
    input load_units, output timeout, output pulse_active);
  modport tick_src (output tick, input tick_clr);
endinterface

// ===== core/ocw_tick_gen.sv
// Prescaler making one watchdog unit tick from mclk.
// Assumes tick_clr is pulsed whenever a countdown is (re)loaded.
`timescale 1ns/1ps
module ocw_tick_gen #(
  parameter int TICK_CYCLES = ocw_pkg::WD_TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Watchdog carrier
  ocw_wdog_if.tick_src wd
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  logic [CW-1:0] cnt;

  // ==========================================================
  // Prescaler, restarted on load so the first unit is full
  always_ff @(posedge mclk)
  begin
    if (!nrst || wd.tick_clr)
    begin
      cnt <= '0;
      wd.tick <= 1'b0;
    end
    else
    begin
      wd.tick <= (cnt == LAST);
      cnt <= (cnt == LAST) ? '0 : cnt + CW'(1);
    end
  end
endmodule

// ===== core/ocw_wdog_timer.sv
// Watchdog countdown and system reset pulse timing.
// Assumes one tick per 250 ms unit from the prescaler.
`timescale 1ns/1ps
module ocw_wdog_timer #(
  parameter int PULSE_CYCLES = ocw_pkg::RST_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Watchdog carrier
  ocw_wdog_if.timer wd
);
  localparam int PW = $clog2(PULSE_CYCLES + 1);
  ocw_pkg::ocw_wd_state_e state;
  logic [ocw_pkg::WD_UNITS_W-1:0] units;
  logic [PW-1:0] pulse_cnt;
  logic enable_q;
  logic rise;

  assign rise = wd.enable & ~enable_q;
  // Expiry on the tick that empties the count; 0 loaded expires at first tick
  assign wd.timeout = (state == ocw_pkg::OCW_WD_COUNT) & wd.enable & ~wd.restart
    & wd.tick & (units <= ocw_pkg::WD_UNITS_W'(1));
  assign wd.tick_clr = ((state == ocw_pkg::OCW_WD_IDLE) & rise) | wd.restart;
  assign wd.pulse_active = (state == ocw_pkg::OCW_WD_PULSE);

  // ==========================================================
  // Countdown state machine
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      state <= ocw_pkg::OCW_WD_IDLE;
      units <= '0;
      pulse_cnt <= '0;
      enable_q <= 1'b0;
    end
    else
    begin
      enable_q <= wd.enable;
      case (state)
        ocw_pkg::OCW_WD_IDLE:
        begin
          if (rise)
          begin
            state <= ocw_pkg::OCW_WD_COUNT;
            units <= wd.load_units;
          end
        end
        ocw_pkg::OCW_WD_COUNT:
        begin
          if (!wd.enable)
            state <= ocw_pkg::OCW_WD_IDLE;
          else if (wd.restart)
            units <= wd.load_units;
          else if (wd.timeout)
          begin
            state <= ocw_pkg::OCW_WD_PULSE;
            pulse_cnt <= PW'(PULSE_CYCLES - 1);
          end
          else if (wd.tick)
            units <= units - ocw_pkg::WD_UNITS_W'(1);
        end
        ocw_pkg::OCW_WD_PULSE:
        begin
          if (pulse_cnt == '0)
            state <= ocw_pkg::OCW_WD_HOLD;
          else
            pulse_cnt <= pulse_cnt - PW'(1);
        end
        ocw_pkg::OCW_WD_HOLD:
        begin
          if (!wd.enable)
            state <= ocw_pkg::OCW_WD_IDLE;
          else if (wd.restart)
          begin
            state <= ocw_pkg::OCW_WD_COUNT;
            units <= wd.load_units;
          end
        end
        default:
          state <= ocw_pkg::OCW_WD_IDLE;
      endcase
    end
  end
endmodule

// ===== core/ocw_freq_ctrl.sv
// Overclock frequency selection, smooth switch assignment and watchdog control.
// Assumes straps stable until power good asserts and synchronous pin inputs.
//
// Notes on behaviour
// - Platform strap 00 link/SATA, 01 dot/SATA, 10 link/PCIe, 11 SATA/PCIe.
// - Dynamic pins 00 keep base, 01..11 pick dynamic N one to three on change.
// - Dynamic enable resets 0; when set, pins steer frequency from chosen base.
// - Programmed mode gives gear times N over M; gear from latched strap.
// - PCIe PLL takes only programmed N; M fixed by the frequency selection.
// - CPU programmed enable resets 0; when set, CPU uses programmed M, and programmed N unless dynamic pins pick one.
// - N fields nine bits, CPU M seven bits, all resetting to zero.
// - PCIe programmed enable resets 0; uses PCIe N; no watchdog recovery.
// - Timeout recovery auto, manual recovery N, hardware straps, or pulse only.
// - Four-bit software index picks one of sixteen CPU frequencies.
// - Override resets 0 selecting straps; when set, software index selects.
// - One smooth switch, auto to overclocking PLL, or host assigned manually.
// - Enabling watchdog starts countdown from timer value times scale.
// - Countdown reaching zero while enabled asserts reset and sets alarm.
// - Timeout reset pulse lasts 20 ms.
// - Reset output enabled only if strap low when power good asserts.
// - Changing scale or timer bits mid countdown restarts from new value.
// - After pulse watchdog idles until reprogrammed or re-enabled.
// - Scale bit 0 gives 250 ms, 1 gives 3 s; resets to 1.
// - Timer value three bits resetting 000; 000 is a test mode.
// - Hardware recovery reloads the strap dividers latched at boot.
`timescale 1ns/1ps
module ocw_freq_ctrl #(
  parameter int TICK_CYCLES = ocw_pkg::WD_TICK_CYCLES,
  parameter int PULSE_CYCLES = ocw_pkg::RST_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Straps and pins
  input wire logic [1:0] platform_sel,
  input wire logic [ocw_pkg::STRAP_W-1:0] freq_strap_bits,
  input wire logic reset_out_strap,
  input wire logic power_good_in_n,
  input wire logic [1:0] dyn_freq_pins,
  // Pin function
  output ocw_pkg::ocw_func_e out_a_func,
  output logic out_b_pcie,
  // CPU PLL
  output ocw_pkg::ocw_src_e cpu_src,
  output logic [ocw_pkg::STRAP_W-1:0] cpu_table_sel,
  output logic [ocw_pkg::STRAP_W-1:0] cpu_gear_sel,
  output logic cpu_n_valid,
  output logic [ocw_pkg::N_W-1:0] cpu_n,
  output logic cpu_m_valid,
  output logic [ocw_pkg::M_W-1:0] cpu_m,
  // PCIe PLL and smooth switch
  output logic pcie_prog_active,
  output logic [ocw_pkg::N_W-1:0] pcie_n,
  output logic [ocw_pkg::STRAP_W-1:0] pcie_m_sel,
  output logic smooth_to_pcie,
  // System reset
  output logic system_reset_out_n,
  output logic system_reset_oe,
  output logic wdog_alarm
);
  // ==========================================================
  // Declarations
  logic booted;
  logic reset_out_en;
  logic [1:0] plat_q;
  logic [ocw_pkg::STRAP_W-1:0] strap_q;
  logic cpu_prog_en;
  logic pcie_prog_en;
  logic dyn_freq_enable;
  logic freq_source_override;
  logic smooth_manual;
  logic smooth_pcie_sel;
  logic [ocw_pkg::IDX_W-1:0] sw_freq_index;
  logic [ocw_pkg::N_W-1:0] cpu_prog_n;
  logic [ocw_pkg::M_W-1:0] cpu_prog_m;
  logic [ocw_pkg::N_W-1:0] pcie_prog_n;
  logic [ocw_pkg::N_W-1:0] rec_n;
  logic [ocw_pkg::M_W-1:0] rec_m;
  logic [ocw_pkg::N_W-1:0] dyn_n [3];
  logic [ocw_pkg::N_W-1:0] dyn_n_cur;
  logic [1:0] dyn_pins_q;
  logic wdog_enable;
  logic wd_scale;
  logic [ocw_pkg::WD_TIMER_W-1:0] wd_timer;
  logic wd_rst_only;
  logic wd_rec_from_n;
  logic autorec;
  logic wdog_enable_q;
  logic wr_ctrl;
  logic wr_wdog;
  logic recover;
  logic dyn_active;
  logic [7:0] next_rdata;
  ocw_wdog_if wd ();

  assign wr_ctrl = reg_wr && reg_addr == ocw_pkg::REG_CTRL;
  assign wr_wdog = reg_wr && reg_addr == ocw_pkg::REG_WDOG;
  // Pulse-only mode skips every divider change
  assign recover = wd.timeout & ~wd_rst_only;
  assign dyn_active = dyn_freq_enable && dyn_pins_q != 2'b00;

  // ==========================================================
  // Watchdog hookup
  assign wd.enable = wdog_enable;
  assign wd.load_units = wd_scale
    ? ocw_pkg::WD_UNITS_W'(int'(wd_timer) * ocw_pkg::WD_LONG_UNITS)
    : ocw_pkg::WD_UNITS_W'(wd_timer);

  ocw_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .mclk(mclk),
    .nrst(nrst),
    .wd(wd)
  );

  ocw_wdog_timer #(.PULSE_CYCLES(PULSE_CYCLES)) u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .wd(wd)
  );

  // ==========================================================
  // Boot strap capture, once, at power good
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      booted <= 1'b0;
      reset_out_en <= 1'b0;
      plat_q <= 2'b00;
      strap_q <= '0;
    end
    else if (!booted && !power_good_in_n)
    begin
      booted <= 1'b1;
      reset_out_en <= ~reset_out_strap;
      plat_q <= platform_sel;
      strap_q <= freq_strap_bits;
    end
  end

  // ==========================================================
  // Control bits; a recovering timeout beats a same-cycle write
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cpu_prog_en <= 1'b0;
      pcie_prog_en <= 1'b0;
      dyn_freq_enable <= 1'b0;
      freq_source_override <= 1'b0;
      smooth_manual <= 1'b0;
      smooth_pcie_sel <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        cpu_prog_en <= reg_wdata[ocw_pkg::CTRL_CPU_PROG];
        pcie_prog_en <= reg_wdata[ocw_pkg::CTRL_PCIE_PROG];
        dyn_freq_enable <= reg_wdata[ocw_pkg::CTRL_DYN_EN];
        freq_source_override <= reg_wdata[ocw_pkg::CTRL_OVERRIDE];
        smooth_manual <= reg_wdata[ocw_pkg::CTRL_SMOOTH_MAN];
        smooth_pcie_sel <= reg_wdata[ocw_pkg::CTRL_SMOOTH_PCIE];
      end
      if (recover)
      begin
        dyn_freq_enable <= 1'b0;
        if (!wd_rec_from_n)
        begin
          // Back to boot straps; PCIe setting left alone
          cpu_prog_en <= 1'b0;
          freq_source_override <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Divider registers and recovery copies
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      cpu_prog_n <= '0;
      cpu_prog_m <= '0;
      pcie_prog_n <= '0;
      rec_n <= '0;
      rec_m <= '0;
      sw_freq_index <= '0;
      wdog_enable_q <= 1'b0;
    end
    else
    begin
      wdog_enable_q <= wdog_enable;
      if (reg_wr)
      begin
        case (reg_addr)
          ocw_pkg::REG_SWIDX: sw_freq_index <= reg_wdata[ocw_pkg::IDX_W-1:0];
          ocw_pkg::REG_CPU_N_LO: cpu_prog_n[7:0] <= reg_wdata;
          ocw_pkg::REG_CPU_NM:
          begin
            cpu_prog_n[8] <= reg_wdata[7];
            cpu_prog_m <= reg_wdata[ocw_pkg::M_W-1:0];
          end
          ocw_pkg::REG_PCIE_N_LO: pcie_prog_n[7:0] <= reg_wdata;
          ocw_pkg::REG_HIGH_BITS:
          begin
            pcie_prog_n[8] <= reg_wdata[ocw_pkg::HB_PCIE_N8];
            if (!autorec)
              rec_n[8] <= reg_wdata[ocw_pkg::HB_REC_N8];
          end
          ocw_pkg::REG_REC_N_LO:
          begin
            if (!autorec)
              rec_n[7:0] <= reg_wdata;
          end
          default: ;
        endcase
      end
      // Snapshot of the running dividers as the watchdog arms
      if (wdog_enable && !wdog_enable_q)
      begin
        rec_m <= cpu_prog_m;
        if (autorec)
          rec_n <= cpu_prog_n;
      end
      if (recover && wd_rec_from_n)
      begin
        cpu_prog_n <= rec_n;
        cpu_prog_m <= rec_m;
      end
    end
  end

  // ==========================================================
  // Dynamic frequency steps, latched only when the pins move
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      dyn_n[0] <= '0;
      dyn_n[1] <= '0;
      dyn_n[2] <= '0;
      dyn_pins_q <= 2'b00;
      dyn_n_cur <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == ocw_pkg::REG_DYN1_LO)
        dyn_n[0][7:0] <= reg_wdata;
      if (reg_wr && reg_addr == ocw_pkg::REG_DYN2_LO)
        dyn_n[1][7:0] <= reg_wdata;
      if (reg_wr && reg_addr == ocw_pkg::REG_DYN3_LO)
        dyn_n[2][7:0] <= reg_wdata;
      if (reg_wr && reg_addr == ocw_pkg::REG_DYN_HI)
      begin
        dyn_n[0][8] <= reg_wdata[0];
        dyn_n[1][8] <= reg_wdata[1];
        dyn_n[2][8] <= reg_wdata[2];
      end
      if (dyn_freq_pins != dyn_pins_q)
      begin
        dyn_pins_q <= dyn_freq_pins;
        if (dyn_freq_pins != 2'b00)
          dyn_n_cur <= dyn_n[dyn_freq_pins - 2'b01];
      end
    end
  end

  // ==========================================================
  // Watchdog register and alarm; the set wins over a clear
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wdog_enable <= 1'b0;
      wd_scale <= ocw_pkg::WD_SCALE_RST;
      wd_timer <= '0;
      wd_rst_only <= 1'b0;
      wd_rec_from_n <= 1'b0;
      autorec <= ocw_pkg::AUTOREC_RST;
      wd.restart <= 1'b0;
      wdog_alarm <= 1'b0;
    end
    else
    begin
      // One cycle late so the reload sees the new timer bits
      wd.restart <= wr_wdog && (reg_wdata[ocw_pkg::WD_SCALE] != wd_scale
        || reg_wdata[ocw_pkg::WD_TIMER_LSB +: ocw_pkg::WD_TIMER_W] != wd_timer);
      if (wr_wdog)
      begin
        wdog_enable <= reg_wdata[ocw_pkg::WD_ENABLE];
        wd_scale <= reg_wdata[ocw_pkg::WD_SCALE];
        wd_timer <= reg_wdata[ocw_pkg::WD_TIMER_LSB +: ocw_pkg::WD_TIMER_W];
        wd_rst_only <= reg_wdata[ocw_pkg::WD_RST_ONLY];
        wd_rec_from_n <= reg_wdata[ocw_pkg::WD_REC_FROM_N];
      end
      if (reg_wr && reg_addr == ocw_pkg::REG_AUTOREC)
        autorec <= reg_wdata[0];
      if (wd.timeout)
        wdog_alarm <= 1'b1;
      else if (wr_wdog && reg_wdata[ocw_pkg::WD_ALARM])
        wdog_alarm <= 1'b0;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      out_a_func <= ocw_pkg::OCW_FUNC_LINK;
      out_b_pcie <= 1'b0;
      cpu_src <= ocw_pkg::OCW_SRC_STRAP;
      cpu_table_sel <= '0;
      cpu_gear_sel <= '0;
      cpu_n_valid <= 1'b0;
      cpu_n <= '0;
      cpu_m_valid <= 1'b0;
      cpu_m <= '0;
      pcie_prog_active <= 1'b0;
      pcie_n <= '0;
      pcie_m_sel <= '0;
      smooth_to_pcie <= 1'b0;
      system_reset_out_n <= 1'b1;
      system_reset_oe <= 1'b0;
    end
    else
    begin
      case (plat_q)
        2'b00: out_a_func <= ocw_pkg::OCW_FUNC_LINK;
        2'b01: out_a_func <= ocw_pkg::OCW_FUNC_DOT;
        2'b10: out_a_func <= ocw_pkg::OCW_FUNC_LINK;
        default: out_a_func <= ocw_pkg::OCW_FUNC_SATA;
      endcase
      out_b_pcie <= plat_q[1];
      if (cpu_prog_en)
        cpu_src <= ocw_pkg::OCW_SRC_PROG;
      else if (freq_source_override)
        cpu_src <= ocw_pkg::OCW_SRC_SWIDX;
      else
        cpu_src <= ocw_pkg::OCW_SRC_STRAP;
      cpu_table_sel <= freq_source_override ? {1'b0, sw_freq_index} : strap_q;
      cpu_gear_sel <= strap_q;
      cpu_n_valid <= cpu_prog_en | dyn_active;
      cpu_n <= dyn_active ? dyn_n_cur : cpu_prog_n;
      cpu_m_valid <= cpu_prog_en;
      cpu_m <= cpu_prog_m;
      pcie_prog_active <= pcie_prog_en;
      pcie_n <= pcie_prog_n;
      pcie_m_sel <= freq_source_override ? {1'b0, sw_freq_index} : strap_q;
      // Auto mode gives the CPU PLL priority when both overclock
      smooth_to_pcie <= smooth_manual ? smooth_pcie_sel
        : (pcie_prog_en & ~(cpu_prog_en | dyn_active));
      system_reset_out_n <= ~(wd.pulse_active & reset_out_en);
      system_reset_oe <= reset_out_en;
    end
  end

  // ==========================================================
  // Read port: data only in the cycle after the strobe
  always_comb
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      ocw_pkg::REG_CTRL: next_rdata = {2'b00, smooth_pcie_sel, smooth_manual,
        freq_source_override, dyn_freq_enable, pcie_prog_en, cpu_prog_en};
      ocw_pkg::REG_SWIDX: next_rdata = {4'h0, sw_freq_index};
      ocw_pkg::REG_CPU_N_LO: next_rdata = cpu_prog_n[7:0];
      ocw_pkg::REG_CPU_NM: next_rdata = {cpu_prog_n[8], cpu_prog_m};
      ocw_pkg::REG_PCIE_N_LO: next_rdata = pcie_prog_n[7:0];
      ocw_pkg::REG_HIGH_BITS: next_rdata = {6'h00, rec_n[8], pcie_prog_n[8]};
      ocw_pkg::REG_REC_N_LO: next_rdata = rec_n[7:0];
      ocw_pkg::REG_WDOG: next_rdata = {wd_rec_from_n, wd_rst_only, wd_timer,
        wd_scale, wdog_alarm, wdog_enable};
      ocw_pkg::REG_AUTOREC: next_rdata = {7'h00, autorec};
      ocw_pkg::REG_DYN1_LO: next_rdata = dyn_n[0][7:0];
      ocw_pkg::REG_DYN2_LO: next_rdata = dyn_n[1][7:0];
      ocw_pkg::REG_DYN3_LO: next_rdata = dyn_n[2][7:0];
      ocw_pkg::REG_DYN_HI: next_rdata = {5'h00, dyn_n[2][8], dyn_n[1][8], dyn_n[0][8]};
      ocw_pkg::REG_STATUS: next_rdata = {1'b0, wd.pulse_active, booted, reset_out_en,
        dyn_pins_q, plat_q};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
  end
endmodule

// ===== sim/ocw_board_model.sv
// Board model: straps and power good seen by ocw_freq_ctrl.
// Assumes the bench owns nrst and the platform strap.
`timescale 1ns/1ps
module ocw_board_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Board pins
  output logic power_good_in_n,
  output logic reset_out_strap,
  output logic [ocw_pkg::STRAP_W-1:0] freq_strap_bits
);
  // ==========================================================
  // Straps and power good
  int cnt;
  // Strap low, so the reset output is usable
  assign reset_out_strap = 1'b0;
  assign freq_strap_bits = 5'h03;
  always_ff @(posedge mclk)
    if (!nrst)
      cnt <= 0;
    else if (cnt < 3)
      cnt <= cnt + 1;
  // Late power good, so straps are settled first
  assign power_good_in_n = (cnt < 3);
endmodule

// ===== sim/ocw_chk_assertions.sv
// Port checker for ocw_freq_ctrl.
// Assumes straps change only while nrst is low.
`timescale 1ns/1ps
module ocw_chk #(
  parameter int PULSE_CYCLES = ocw_pkg::RST_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Watched ports
  input wire logic [1:0] platform_sel,
  input wire logic reset_out_strap,
  input wire logic out_b_pcie,
  input wire ocw_pkg::ocw_src_e cpu_src,
  input wire logic [ocw_pkg::STRAP_W-1:0] cpu_table_sel,
  input wire logic cpu_m_valid,
  input wire logic [ocw_pkg::STRAP_W-1:0] pcie_m_sel,
  input wire logic system_reset_out_n,
  input wire logic system_reset_oe,
  input wire logic wdog_alarm
);
  // ==========================================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  int lo_cnt;
  // Counter, since the pulse is too long to unroll
  always_ff @(posedge mclk)
    if (!nrst || system_reset_out_n)
      lo_cnt <= 0;
    else
      lo_cnt <= lo_cnt + 1;
  property p_plat;
    out_b_pcie |-> platform_sel[1];
  endproperty
  a_plat: assert property (p_plat) else $error("pin b function wrong");
  property p_prog;
    cpu_m_valid |-> cpu_src == ocw_pkg::OCW_SRC_PROG;
  endproperty
  a_prog: assert property (p_prog) else $error("divider source wrong");
  property p_tab;
    pcie_m_sel == cpu_table_sel;
  endproperty
  a_tab: assert property (p_tab) else $error("pcie m select differs");
  property p_idx;
    cpu_src == ocw_pkg::OCW_SRC_SWIDX |-> !cpu_table_sel[4];
  endproperty
  a_idx: assert property (p_idx) else $error("index out of range");
  property p_oe;
    system_reset_oe |-> !reset_out_strap;
  endproperty
  a_oe: assert property (p_oe) else $error("reset output enabled");
  property p_low;
    !system_reset_out_n |-> system_reset_oe && wdog_alarm;
  endproperty
  a_low: assert property (p_low) else $error("reset without alarm");
  property p_pulse;
    $rose(system_reset_out_n) |-> lo_cnt == PULSE_CYCLES;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length wrong");
  property p_alarm;
    $rose(wdog_alarm) && system_reset_oe |-> ##[1:3] !system_reset_out_n;
  endproperty
  a_alarm: assert property (p_alarm) else $error("no reset after alarm");
  c_pulse: cover property ($fell(system_reset_out_n));
  c_idx: cover property (cpu_src == ocw_pkg::OCW_SRC_SWIDX);
  c_pcie: cover property (out_b_pcie);
endmodule
bind ocw_freq_ctrl ocw_chk #(.PULSE_CYCLES(PULSE_CYCLES)) i_ocw_chk (.mclk, .nrst,
  .platform_sel, .reset_out_strap, .out_b_pcie, .cpu_src, .cpu_table_sel, .cpu_m_valid,
  .pcie_m_sel, .system_reset_out_n, .system_reset_oe, .wdog_alarm);

// ===== sim/ocw_freq_ctrl_tb.sv
// Self-checking bench for ocw_freq_ctrl.
// Assumes short tick and pulse counts.
`timescale 1ns/1ps
module ocw_freq_ctrl_tb;
  // ==========================================================
  // Signals and instances
  logic mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_v;
  logic [1:0] platform_sel = 2'h0, dyn_freq_pins = 2'h0;
  logic [4:0] fsb, cpu_table_sel, gear;
  logic rstrap, pgn, out_b_pcie, cpu_n_valid, cpu_m_valid, pcie_prog_active;
  logic smooth_to_pcie, system_reset_out_n, system_reset_oe, wdog_alarm;
  ocw_pkg::ocw_func_e out_a_func;
  ocw_pkg::ocw_src_e cpu_src;
  logic [8:0] cpu_n, pcie_n;
  logic [6:0] cpu_m;
  int err_total = 0, cmp_count = 0, n;
  always #5 mclk = ~mclk;
  ocw_freq_ctrl #(.TICK_CYCLES(10), .PULSE_CYCLES(5)) i_ocw_freq_ctrl (.mclk, .nrst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .platform_sel,
    .freq_strap_bits(fsb), .reset_out_strap(rstrap), .power_good_in_n(pgn), .dyn_freq_pins,
    .out_a_func, .out_b_pcie, .cpu_src, .cpu_table_sel, .cpu_gear_sel(gear), .cpu_n_valid,
    .cpu_n, .cpu_m_valid, .cpu_m, .pcie_prog_active, .pcie_n, .pcie_m_sel(),
    .smooth_to_pcie, .system_reset_out_n, .system_reset_oe, .wdog_alarm);
  ocw_board_model i_ocw_board_model (.mclk, .nrst, .power_good_in_n(pgn),
    .reset_out_strap(rstrap), .freq_strap_bits(fsb));
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  task do_reset(input logic [1:0] p);
    @(posedge mclk);
    nrst <= 1'b0;
    platform_sel <= p;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    cyc(8);
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    rd(ocw_pkg::REG_WDOG);
    chk("wdog", rd_v, 8'h04);
    rd(ocw_pkg::REG_AUTOREC);
    chk("autorec", rd_v, 8'h01);
    rd(ocw_pkg::REG_CTRL);
    chk("ctrl", rd_v, 8'h00);
    rd(ocw_pkg::REG_CPU_NM);
    chk("n m", rd_v, 8'h00);
  endtask
  task t_plat;
    for (int p = 0; p < 4; p++)
    begin
      do_reset(p[1:0]);
      chk("func a", out_a_func, (p == 3) ? 2'h2 : {1'b0, p == 1});
      chk("func b", out_b_pcie, p[1]);
      chk("oe", system_reset_oe, 1'b1);
      chk("gear", gear, 5'h03);
    end
  endtask
  task t_prog;
    wr(ocw_pkg::REG_CPU_N_LO, 8'h34);
    wr(ocw_pkg::REG_CPU_NM, 8'h85);
    wr(ocw_pkg::REG_CTRL, 8'h01);
    cyc(3);
    chk("src", cpu_src, ocw_pkg::OCW_SRC_PROG);
    chk("n", cpu_n, 9'h134);
    chk("m", cpu_m, 7'h05);
    wr(ocw_pkg::REG_SWIDX, 8'h0F);
    wr(ocw_pkg::REG_CTRL, 8'h08);
    cyc(3);
    chk("src", cpu_src, ocw_pkg::OCW_SRC_SWIDX);
    chk("index", cpu_table_sel, 5'h0F);
  endtask
  task t_dyn;
    wr(ocw_pkg::REG_DYN1_LO, 8'h11);
    wr(ocw_pkg::REG_DYN2_LO, 8'h22);
    wr(ocw_pkg::REG_DYN3_LO, 8'h33);
    wr(ocw_pkg::REG_DYN_HI, 8'h05);
    wr(ocw_pkg::REG_CTRL, 8'h04);
    for (int i = 1; i < 5; i++)
    begin
      @(posedge mclk);
      dyn_freq_pins <= i[1:0];
      cyc(3);
      if (i < 4)
        chk("dyn n", cpu_n, {i != 2, i[3:0], i[3:0]});
      else
        chk("dyn off", cpu_n_valid, 1'b0);
    end
  endtask
  task t_pcie;
    wr(ocw_pkg::REG_PCIE_N_LO, 8'h9A);
    wr(ocw_pkg::REG_HIGH_BITS, 8'h01);
    wr(ocw_pkg::REG_CTRL, 8'h02);
    cyc(3);
    chk("pcie on", pcie_prog_active, 1'b1);
    chk("pcie n", pcie_n, 9'h19A);
    chk("smooth auto", smooth_to_pcie, 1'b1);
    wr(ocw_pkg::REG_CTRL, 8'h12);
    cyc(3);
    chk("smooth manual", smooth_to_pcie, 1'b0);
  endtask
  task t_wd;
    wr(ocw_pkg::REG_CTRL, 8'h09);
    wr(ocw_pkg::REG_WDOG, 8'h09);
    for (n = 0; n < 60 && system_reset_out_n; n++)
      cyc(1);
    chk("wait", n > 8 && n < 20, 1'b1);
    chk("alarm", wdog_alarm, 1'b1);
    for (n = 0; n < 20 && !system_reset_out_n; n++)
      cyc(1);
    chk("pulse", n, 16'h5);
    chk("recovered", cpu_m_valid, 1'b0);
    chk("rec src", cpu_src, ocw_pkg::OCW_SRC_STRAP);
    cyc(40);
    chk("hold", system_reset_out_n, 1'b1);
    wr(ocw_pkg::REG_WDOG, 8'h13);
    for (n = 0; n < 60 && system_reset_out_n; n++)
      cyc(1);
    chk("restart", n > 18 && n < 40, 1'b1);
  endtask
  task results;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    do_reset(2'h0);
    t_reset;
    t_plat;
    t_prog;
    t_dyn;
    t_pcie;
    t_wd;
    results;
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    err_total++;
    results;
  end
endmodule
